// ==== rtl/power_ctl_consts.svh ====
// Purpose: Offsets, field positions, reset values and counts of the power control block
// Assumes: Word-indexed register port, 16-bit data
// Notes: Included by bare name
`ifndef POWER_CTL_CONSTS_SVH
`define POWER_CTL_CONSTS_SVH
`define ADDR_DEEP_SLEEP_CONTROL 4'h0
`define ADDR_WAKE_SOURCE 4'h1
`define ADDR_RESET_CAUSE 4'h2
`define ADDR_CLOCK_DIVIDER 4'h3
`define ADDR_MODULE_DISABLE 4'h4
`define ADDR_MODULE_ENABLE 4'h5
`define ADDR_MODULE_IDLE_STOP 4'h6
`define ADDR_SCRATCH0 4'h7
`define ADDR_SCRATCH1 4'h8
`define BIT_ARM 15
`define BIT_BROWNOUT 1
`define BIT_HOLD 0
`define BIT_WAKE_EXT 8
`define BIT_WAKE_FAULT 7
`define BIT_WAKE_WDT 4
`define BIT_WAKE_ALARM 3
`define BIT_WAKE_MASTER_RESET_PIN 2
`define BIT_WAKE_POR 0
`define BIT_DEEP_EXIT 10
`define BIT_RETURN_ON_IRQ 15
`define POS_DOZE_RATIO 12
`define BIT_SLOW_ENABLE 11
`define WAKE_SOURCE_MASK 16'h019D
`define RESET_ZERO16 16'h0000
`define POR_SEQ_TIME_NS 1000
`define POR_SEQ_CYCLES ((`POR_SEQ_TIME_NS + 7) / 8)
`endif

// ==== rtl/power_ctl_pkg.sv ====
// Purpose: Types of the power control block
// Assumes: Nothing beyond the consts header
// Notes: States are one-hot
package power_ctl_pkg;
    typedef enum logic [3:0] {
        st_run = 4'h1,
        st_sleep = 4'h2,
        st_deep = 4'h4,
        st_wake_seq = 4'h8
    } mode_type;
endpackage : power_ctl_pkg

// ==== rtl/deep_sleep_doze_power_control.sv ====
// Purpose: Deep sleep, I/O hold, doze clock divider and module gating
// Assumes: Word-indexed register port, read data one cycle after strobe
// Notes: Deep-sleep bits survive reset; only true_por clears them;
// the wake sequence length is a parameter so a bench can shorten it
//
// How it works
// - Sleep instruction with arm bit set enters deep, else ordinary sleep.
// - Wake event leaves deep sleep and hardware clears the arm bit.
// - Brownout in deep sleep sets status flag; it never wakes.
// - Hold bit set freezes pins; clear lets latch and direction drive.
// - Hardware sets hold bit, software may only clear it.
// - Of the resets, only true power-on reset clears the arm, brownout and hold bits.
// - Alarm in deep sleep sets the alarm wake flag.
// - Master reset pin in deep sleep sets its wake flag.
// - Wake flags other than power-on settable only in deep sleep.
// - Power-on wake flag settable at any time except during the wake sequence.
// - Slow enable divides the CPU clock; peripherals stay full rate.
// - Three-bit ratio picks 1:1 to 1:128, default 1:1.
// - Return-on-interrupt set: interrupt restores CPU full speed.
// - CPU enable pulses stay aligned to the peripheral clock.
// - Disabled module: clocks gated, writes ignored, reads invalid.
// - Cleared enable stops function, registers stay accessible.
// - Stop-in-idle bit halts module in idle; default keeps running.
// - Deep wake acts as power-on reset, scratch registers retained.
// - Pending irq cleared on entry; wakes during power-on sequence dropped.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "power_ctl_consts.svh"
module deep_sleep_doze_power_control #(
    parameter int NUM_MODULES = 16,
    parameter int NUM_PINS = 16,
    parameter int POR_SEQ_CYCLES = `POR_SEQ_CYCLES
) (
    input wire logic core_clk, // System clock
    input wire logic reset, // Sync reset, active high
    input wire logic true_por, // Power-on reset seen outside deep sleep
    input wire logic [3:0] reg_addr, // Register word index
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    output logic [15:0] reg_rdata, // Read data, cycle after strobe
    input wire logic sleep_instr, // Power-save sleep instruction pulse
    input wire logic idle_instr, // Power-save idle instruction pulse
    input wire logic wake_ext_irq, // External interrupt zero change
    input wire logic wake_fault, // Fault detected
    input wire logic wake_watchdog, // Deep sleep watchdog time-out
    input wire logic wake_alarm, // Calendar alarm
    input wire logic wake_master_reset, // Master reset pin asserted
    input wire logic por_event, // Power-on reset circuit event
    input wire logic brownout_event, // Deep brownout detect
    input wire logic brownout_monitor_on, // Deep brownout monitor active
    input wire logic irq_any, // Any interrupt request
    input wire logic [NUM_PINS-1:0] output_latch, // Pin latch values
    input wire logic [NUM_PINS-1:0] direction_register, // 1 = input
    output logic [NUM_PINS-1:0] pin_out, // Pin drive level
    output logic [NUM_PINS-1:0] pin_oe, // Pin output enable
    output logic io_hold, // Pins frozen
    output logic deep_sleep_active, // In deep sleep
    output logic sleep_active, // In ordinary sleep
    output logic idle_active, // In idle
    output logic wake_reset, // Power-on reset request on wake
    output logic irq_flush, // Clear pending interrupts
    output logic cpu_clk_en, // CPU clock enable pulse
    output logic periph_clk_en, // Peripheral clock enable
    output logic [NUM_MODULES-1:0] module_clk_en, // Per-module clock gate
    output logic [NUM_MODULES-1:0] module_run, // Per-module function on
    output logic [NUM_MODULES-1:0] module_regs_valid // Module SFRs usable
);
    // ************************************************************
    // Mode state
    // ************************************************************
    power_ctl_pkg::mode_type mode_ff, nxt_mode;
    logic arm_ff, brownout_ff, hold_ff;
    logic [15:0] wake_ff, scratch0_ff, scratch1_ff;
    logic exit_flag_ff;
    logic [15:0] seq_cnt_ff;
    logic [15:0] rdata_ff;
    logic idle_ff;
    logic [NUM_PINS-1:0] frz_out_ff, frz_oe_ff;
    logic [2:0] ratio_ff, ratio_act_ff;
    logic slow_ff, roi_ff;
    logic [6:0] div_cnt_ff;
    logic [NUM_MODULES-1:0] mod_dis_ff, mod_en_ff, mod_idl_ff;

    wire in_deep = (mode_ff == power_ctl_pkg::st_deep);
    wire in_seq = (mode_ff == power_ctl_pkg::st_wake_seq);
    // Brownout is status only, so it is absent from the wake term
    wire any_wake = wake_ext_irq | wake_fault | wake_watchdog |
        wake_alarm | wake_master_reset | por_event;
    wire seq_done = (seq_cnt_ff == 16'(POR_SEQ_CYCLES - 1));
    wire [15:0] wake_set = {7'h00, wake_ext_irq, wake_fault, 2'b00,
        wake_watchdog, wake_alarm, wake_master_reset, 1'b0, 1'b0}
        & {16{in_deep}};
    wire [15:0] por_set = {15'h0000, por_event & ~in_seq};

    always_comb begin
        nxt_mode = mode_ff;
        unique case (mode_ff)
            power_ctl_pkg::st_run: begin
                if (sleep_instr) begin
                    nxt_mode = arm_ff ? power_ctl_pkg::st_deep
                        : power_ctl_pkg::st_sleep;
                end
            end
            power_ctl_pkg::st_sleep: begin
                if (irq_any | any_wake) begin
                    nxt_mode = power_ctl_pkg::st_run;
                end
            end
            power_ctl_pkg::st_deep: begin
                if (any_wake) begin
                    nxt_mode = power_ctl_pkg::st_wake_seq;
                end
            end
            power_ctl_pkg::st_wake_seq: begin
                if (seq_done) begin
                    nxt_mode = power_ctl_pkg::st_run;
                end
            end
            default: nxt_mode = power_ctl_pkg::st_run;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_ff <= power_ctl_pkg::st_run;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // Counts the power-on sequence that follows a deep wake
    always_ff @(posedge core_clk) begin
        if (reset || !in_seq) begin
            seq_cnt_ff <= `RESET_ZERO16;
        end else begin
            seq_cnt_ff <= seq_cnt_ff + 16'h0001;
        end
    end

    // Idle ends on any interrupt or a sleep request
    always_ff @(posedge core_clk) begin
        if (reset || sleep_instr || irq_any) begin
            idle_ff <= 1'b0;
        end else if (idle_instr) begin
            idle_ff <= 1'b1;
        end
    end

    // ************************************************************
    // Register decode
    // ************************************************************
    wire wr_dsc = reg_write && (reg_addr == `ADDR_DEEP_SLEEP_CONTROL);
    wire wr_wake = reg_write && (reg_addr == `ADDR_WAKE_SOURCE);
    wire wr_rcause = reg_write && (reg_addr == `ADDR_RESET_CAUSE);
    wire wr_div = reg_write && (reg_addr == `ADDR_CLOCK_DIVIDER);
    wire wr_dis = reg_write && (reg_addr == `ADDR_MODULE_DISABLE);
    wire wr_en = reg_write && (reg_addr == `ADDR_MODULE_ENABLE);
    wire wr_idl = reg_write && (reg_addr == `ADDR_MODULE_IDLE_STOP);
    wire wr_s0 = reg_write && (reg_addr == `ADDR_SCRATCH0);
    wire wr_s1 = reg_write && (reg_addr == `ADDR_SCRATCH1);
    // Software may only write zeros into flags; set wins over clear
    wire [15:0] wake_keep = wr_wake ? (wake_ff & reg_wdata) : wake_ff;
    wire [15:0] nxt_wake = (wake_keep | wake_set | por_set)
        & `WAKE_SOURCE_MASK;
    wire enter_deep = (mode_ff == power_ctl_pkg::st_run) && sleep_instr
        && arm_ff;
    // Hardware terms of the deep domain; hardware beats a same-cycle write
    wire arm_clear = in_deep && any_wake;
    wire brownout_set = in_deep && brownout_monitor_on && brownout_event;
    wire hold_clear = wr_dsc && !reg_wdata[`BIT_HOLD];
    wire exit_clear = wr_rcause && !reg_wdata[`BIT_DEEP_EXIT];

    // ************************************************************
    // Deep sleep domain (survives ordinary reset)
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (true_por) begin
            arm_ff <= 1'b0;
            brownout_ff <= 1'b0;
            hold_ff <= 1'b0;
            wake_ff <= `RESET_ZERO16;
            scratch0_ff <= `RESET_ZERO16;
            scratch1_ff <= `RESET_ZERO16;
            exit_flag_ff <= 1'b0;
        end else begin
            if (arm_clear) begin
                arm_ff <= 1'b0;
            end else if (wr_dsc) begin
                arm_ff <= reg_wdata[`BIT_ARM];
            end
            if (brownout_set) begin
                brownout_ff <= 1'b1;
            end else if (wr_dsc) begin
                brownout_ff <= reg_wdata[`BIT_BROWNOUT];
            end
            if (enter_deep) begin
                hold_ff <= 1'b1;
            end else if (hold_clear) begin
                hold_ff <= 1'b0;
            end
            wake_ff <= nxt_wake;
            if (enter_deep) begin
                exit_flag_ff <= 1'b1;
            end else if (exit_clear) begin
                exit_flag_ff <= 1'b0;
            end
            if (wr_s0) begin
                scratch0_ff <= reg_wdata;
            end
            if (wr_s1) begin
                scratch1_ff <= reg_wdata;
            end
        end
    end

    // ************************************************************
    // Pin hold
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (true_por) begin
            frz_out_ff <= '0;
            frz_oe_ff <= '0;
        end else if (!hold_ff) begin
            // Track live pin state so the freeze catches entry values
            frz_out_ff <= output_latch;
            frz_oe_ff <= ~direction_register;
        end
    end
    assign pin_out = hold_ff ? frz_out_ff : output_latch;
    assign pin_oe = hold_ff ? frz_oe_ff : ~direction_register;

    // ************************************************************
    // Doze divider and module control
    // ************************************************************
    // A deep wake restarts the CPU-side registers like a power-on reset
    wire cpu_side_reset = reset || in_seq;
    // Disabled modules ignore writes to their enable and idle bits
    wire [NUM_MODULES-1:0] wr_mod = reg_wdata[NUM_MODULES-1:0];
    wire [NUM_MODULES-1:0] nxt_mod_en = (mod_en_ff & mod_dis_ff)
        | (wr_mod & ~mod_dis_ff);
    wire [NUM_MODULES-1:0] nxt_mod_idl = (mod_idl_ff & mod_dis_ff)
        | (wr_mod & ~mod_dis_ff);
    wire doze_on = slow_ff && !(roi_ff && irq_any);
    wire [6:0] div_top = 7'((8'h01 << ratio_act_ff) - 8'h01);
    wire div_wrap = (div_cnt_ff >= div_top);

    always_ff @(posedge core_clk) begin
        if (cpu_side_reset) begin
            ratio_ff <= 3'h0;
            slow_ff <= 1'b0;
            roi_ff <= 1'b0;
            mod_dis_ff <= '0;
            mod_en_ff <= '0;
            mod_idl_ff <= '0;
        end else begin
            if (wr_div) begin
                roi_ff <= reg_wdata[`BIT_RETURN_ON_IRQ];
                ratio_ff <= reg_wdata[`POS_DOZE_RATIO +: 3];
                slow_ff <= reg_wdata[`BIT_SLOW_ENABLE];
            end else if (roi_ff && irq_any) begin
                slow_ff <= 1'b0;
            end
            if (wr_dis) begin
                mod_dis_ff <= wr_mod;
            end
            if (wr_en) begin
                mod_en_ff <= nxt_mod_en;
            end
            if (wr_idl) begin
                mod_idl_ff <= nxt_mod_idl;
            end
        end
    end

    // Restart whenever doze drops, so the first slow pulse is whole
    always_ff @(posedge core_clk) begin
        if (reset || !doze_on) begin
            div_cnt_ff <= 7'h00;
            ratio_act_ff <= ratio_ff;
        end else if (div_wrap) begin
            div_cnt_ff <= 7'h00;
            ratio_act_ff <= ratio_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff + 7'h01;
        end
    end

    wire cpu_stop = (mode_ff != power_ctl_pkg::st_run) || idle_ff;
    // Same clock, one enable: peripherals and CPU never drift apart
    assign cpu_clk_en = !cpu_stop && (!doze_on || div_wrap);
    assign periph_clk_en = (mode_ff == power_ctl_pkg::st_run);
    // Idle halts only the modules that asked for it
    wire [NUM_MODULES-1:0] idle_gate = {NUM_MODULES{idle_ff}} & mod_idl_ff;
    assign module_clk_en = ~mod_dis_ff & ~idle_gate
        & {NUM_MODULES{periph_clk_en}};
    assign module_run = module_clk_en & mod_en_ff;
    assign module_regs_valid = ~mod_dis_ff;

    // ************************************************************
    // Read port
    // ************************************************************
    wire [15:0] pad_dis = 16'(mod_dis_ff);
    // Disabled bits read back as ones, a deliberately invalid value
    wire [15:0] pad_en = 16'(mod_en_ff | mod_dis_ff);
    wire [15:0] pad_idl = 16'(mod_idl_ff | mod_dis_ff);
    wire [15:0] rd_dsc = {arm_ff, 13'h0000, brownout_ff, hold_ff};
    wire [15:0] rd_div = {roi_ff, ratio_ff, slow_ff, 11'h000};
    wire [15:0] rd_rc = {5'h00, exit_flag_ff, 10'h000};
    // An unmapped index reads as zero
    wire [15:0] rd_mux =
        (reg_addr == `ADDR_DEEP_SLEEP_CONTROL) ? rd_dsc :
        (reg_addr == `ADDR_WAKE_SOURCE) ? wake_ff :
        (reg_addr == `ADDR_RESET_CAUSE) ? rd_rc :
        (reg_addr == `ADDR_CLOCK_DIVIDER) ? rd_div :
        (reg_addr == `ADDR_MODULE_DISABLE) ? pad_dis :
        (reg_addr == `ADDR_MODULE_ENABLE) ? pad_en :
        (reg_addr == `ADDR_MODULE_IDLE_STOP) ? pad_idl :
        (reg_addr == `ADDR_SCRATCH0) ? scratch0_ff :
        (reg_addr == `ADDR_SCRATCH1) ? scratch1_ff : `RESET_ZERO16;

    // Read data stand for one cycle, then fall back to zero
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata_ff <= `RESET_ZERO16;
        end else if (reg_read) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= `RESET_ZERO16;
        end
    end

    assign reg_rdata = rdata_ff;
    assign io_hold = hold_ff;
    assign deep_sleep_active = in_deep;
    assign sleep_active = (mode_ff == power_ctl_pkg::st_sleep);
    assign idle_active = idle_ff;
    assign wake_reset = in_seq;
    assign irq_flush = enter_deep;
endmodule : deep_sleep_doze_power_control

// ==== verif/power_ctl_monitor.sv ====
// Purpose: Port-level checks of the power control block
// Assumes: One clock, sync active-high reset
// Notes: Bound from the bench top file
`timescale 1ns/1ps
module power_ctl_monitor #(
    parameter int NUM_MODULES = 16,
    parameter int NUM_PINS = 16,
    parameter int POR_SEQ_CYCLES = 125
) (
    input wire logic core_clk, // Clock
    input wire logic reset, // Sync reset
    input wire logic true_por, // Power-on reset
    input wire logic wake_ext_irq, // Wake input
    input wire logic wake_fault, // Wake input
    input wire logic wake_watchdog, // Wake input
    input wire logic wake_alarm, // Wake input
    input wire logic wake_master_reset, // Wake input
    input wire logic por_event, // Power-on event
    input wire logic brownout_event, // Brownout detect
    input wire logic [NUM_PINS-1:0] output_latch, // Latch values
    input wire logic [NUM_PINS-1:0] direction_register, // 1 = input
    input wire logic [NUM_PINS-1:0] pin_out, // Pin level
    input wire logic [NUM_PINS-1:0] pin_oe, // Pin enable
    input wire logic io_hold, // Pins frozen
    input wire logic deep_sleep_active, // Deep sleep
    input wire logic sleep_active, // Ordinary sleep
    input wire logic idle_active, // Idle
    input wire logic wake_reset, // Wake sequence
    input wire logic irq_flush, // Pending irq clear
    input wire logic cpu_clk_en, // CPU enable
    input wire logic periph_clk_en, // Peripheral enable
    input wire logic [NUM_MODULES-1:0] module_clk_en, // Module gate
    input wire logic [NUM_MODULES-1:0] module_run // Module on
);
    // ********************************
    // Helper logic and assertions
    // ********************************
    logic [15:0] seq_cnt_ff;
    logic [15:0] nxt_seq_cnt;
    logic any_wake;
    assign any_wake = wake_ext_irq | wake_fault | wake_watchdog |
        wake_alarm | wake_master_reset;
    assign nxt_seq_cnt = wake_reset ? seq_cnt_ff + 16'h0001 : 16'h0000;
    always_ff @(posedge core_clk) begin
        seq_cnt_ff <= reset ? 16'h0000 : nxt_seq_cnt;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_deep_holds_io: assert property (deep_sleep_active |-> io_hold)
        else $error("io hold low in deep sleep");
    a_flush_enters: assert property (irq_flush |=> deep_sleep_active)
        else $error("flush without deep entry");
    a_wake_exits: assert property (deep_sleep_active && any_wake
        |=> wake_reset && !deep_sleep_active) else $error("wake ignored");
    a_brownout_stays: assert property (deep_sleep_active &&
        brownout_event && !any_wake && !por_event && !true_por
        |=> deep_sleep_active) else $error("brownout woke device");
    a_hold_freezes: assert property (io_hold && $past(io_hold)
        |-> $stable(pin_out) && $stable(pin_oe)) else $error("pins moved");
    a_release_follows: assert property (!io_hold |->
        pin_out == output_latch && pin_oe == ~direction_register)
        else $error("released pins wrong");
    a_periph_full: assert property (!deep_sleep_active &&
        !sleep_active && !idle_active && !wake_reset |-> periph_clk_en)
        else $error("peripheral clock slowed");
    a_gate_stops_run: assert property (
        (module_run & ~module_clk_en) == '0) else $error("gated module runs");
    a_wake_seq_len: assert property ($fell(wake_reset)
        |-> seq_cnt_ff == 16'(POR_SEQ_CYCLES)) else $error("wake seq length");
    a_one_sleep_mode: assert property (
        !(deep_sleep_active && sleep_active)) else $error("two sleep modes");
    c_deep_entry: cover property ($rose(deep_sleep_active));
    c_wake_done: cover property ($fell(wake_reset));
    c_doze_gap: cover property (cpu_clk_en ##1 !cpu_clk_en);
endmodule : power_ctl_monitor

// ==== verif/cpu_side_model.sv ====
// Purpose: CPU core issuing power-save instructions
// Assumes: Bench raises a request for one cycle
// Notes: Software register writes are made by the bench
`timescale 1ns/1ps
module cpu_side_model (
    input wire logic core_clk, // Clock
    input wire logic sleep_req, // Bench asks for sleep
    input wire logic idle_req, // Bench asks for idle
    output logic sleep_instr, // Power-save sleep pulse
    output logic idle_instr // Power-save idle pulse
);
    // Executed one edge after the request, as a real fetch would be
    always @(posedge core_clk) begin
        sleep_instr <= sleep_req;
        idle_instr <= idle_req;
    end
endmodule : cpu_side_model

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench of the power control block
// Assumes: Wake sequence shortened to 4 cycles
// Notes: Registers reached by word index
`timescale 1ns/1ps
module tb_top;
    localparam int SEQ = 4;
    logic core_clk = 1'b0, reset = 1'b1, true_por = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, pin_out, pin_oe;
    logic reg_write = 1'b0, reg_read = 1'b0, sleep_req = 1'b0;
    logic idle_req = 1'b0, sleep_instr, idle_instr, irq_any = 1'b0;
    logic wake_ext_irq = 1'b0, wake_fault = 1'b0, wake_watchdog = 1'b0;
    logic wake_alarm = 1'b0, wake_master_reset = 1'b0, por_event = 1'b0;
    logic brownout_event = 1'b0, brownout_monitor_on = 1'b1;
    logic [15:0] output_latch = 16'hA5C3, direction_register = 16'h0F0F;
    logic io_hold, deep_sleep_active, sleep_active, idle_active;
    logic wake_reset, irq_flush, cpu_clk_en, periph_clk_en;
    logic [15:0] module_clk_en, module_run, module_regs_valid;
    int failures = 0, cmp_count = 0, n, c, r;
    always #4 core_clk = ~core_clk;
    cpu_side_model u_cpu_side_model (.core_clk, .sleep_req, .idle_req,
        .sleep_instr, .idle_instr);
    deep_sleep_doze_power_control #(.POR_SEQ_CYCLES(SEQ))
        u_deep_sleep_doze_power_control (.core_clk, .reset, .true_por,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .sleep_instr, .idle_instr, .wake_ext_irq, .wake_fault,
        .wake_watchdog, .wake_alarm, .wake_master_reset, .por_event,
        .brownout_event, .brownout_monitor_on, .irq_any, .output_latch,
        .direction_register, .pin_out, .pin_oe, .io_hold,
        .deep_sleep_active, .sleep_active, .idle_active, .wake_reset,
        .irq_flush, .cpu_clk_en, .periph_clk_en, .module_clk_en,
        .module_run, .module_regs_valid);
    // ********************************
    // Shared tasks
    // ********************************
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, e);
        @(posedge core_clk);
    endtask : rd
    task automatic go(input logic s, input logic i);
        sleep_req <= s;
        idle_req <= i;
        @(posedge core_clk);
        sleep_req <= 1'b0;
        idle_req <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask : go
    task automatic rst_pulse();
        @(posedge core_clk);
        reset <= 1'b1;
        @(posedge core_clk);
        reset <= 1'b0;
    endtask : rst_pulse
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_flags();
        rd(4'h0, 16'h0000);
        rd(4'hF, 16'h0000);
        wr(4'h0, 16'h0001);
        rd(4'h0, 16'h0000);
        wake_master_reset <= 1'b1;
        @(posedge core_clk);
        wake_master_reset <= 1'b0;
        wr(4'h1, 16'h019D);
        rd(4'h1, 16'h0000);
        por_event <= 1'b1;
        @(posedge core_clk);
        por_event <= 1'b0;
        rd(4'h1, 16'h0001);
        wr(4'h1, 16'h0000);
        rd(4'h1, 16'h0000);
        $display("flags test done");
    endtask : t_flags
    task automatic t_deep();
        wr(4'h7, 16'hBEEF);
        wr(4'h0, 16'h8000);
        rst_pulse();
        rd(4'h0, 16'h8000);
        go(1'b1, 1'b0);
        chk({15'h0, deep_sleep_active}, 16'h0001);
        @(posedge core_clk);
        brownout_event <= 1'b1;
        @(posedge core_clk);
        brownout_event <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk({15'h0, deep_sleep_active}, 16'h0001);
        wake_alarm <= 1'b1;
        wake_master_reset <= 1'b1;
        @(posedge core_clk);
        wake_alarm <= 1'b0;
        wake_master_reset <= 1'b0;
        output_latch <= 16'h5A3C;
        direction_register <= 16'hFF00;
        // Wakes inside the power-on sequence must leave no flag
        wake_fault <= 1'b1;
        por_event <= 1'b1;
        #1;
        for (n = 0; n < 64 && wake_reset === 1'b1; n++) begin
            @(posedge core_clk);
            wake_fault <= 1'b0;
            por_event <= 1'b0;
            #1;
        end
        chk(16'(n), 16'(SEQ));
        if (n == 64) end_of_test();
        chk(pin_out, 16'hA5C3);
        chk(pin_oe, 16'hF0F0);
        rd(4'h0, 16'h0003);
        rd(4'h1, 16'h000C);
        rd(4'h2, 16'h0400);
        rd(4'h7, 16'hBEEF);
        wr(4'h2, 16'h0000);
        wr(4'h1, 16'h0000);
        rd(4'h2, 16'h0000);
        wr(4'h0, 16'h0000);
        #1;
        chk(pin_out, 16'h5A3C);
        chk(pin_oe, 16'h00FF);
        go(1'b1, 1'b0);
        chk({14'h0, deep_sleep_active, sleep_active}, 16'h0001);
        @(posedge core_clk);
        wake_alarm <= 1'b1;
        @(posedge core_clk);
        wake_alarm <= 1'b0;
        rd(4'h1, 16'h0000);
        rst_pulse();
        $display("deep sleep test done");
    endtask : t_deep
    task automatic t_doze();
        rd(4'h3, 16'h0000);
        for (r = 0; r < 8; r++) begin
            wr(4'h3, 16'h0800 | 16'(r << 12));
            repeat (128) @(posedge core_clk);
            c = 0;
            repeat (256) begin
                @(posedge core_clk);
                #1;
                c += int'(cpu_clk_en === 1'b1);
            end
            chk(16'(c), 16'(256 >> r));
        end
        wr(4'h3, 16'hF800);
        irq_any <= 1'b1;
        repeat (3) @(posedge core_clk);
        irq_any <= 1'b0;
        #1;
        chk({15'h0, cpu_clk_en}, 16'h0001);
        rd(4'h3, 16'hF000);
        $display("doze test done");
    endtask : t_doze
    task automatic t_modules();
        wr(4'h5, 16'hFFFF);
        wr(4'h4, 16'h0001);
        #1;
        chk(module_clk_en & 16'h0003, 16'h0002);
        chk(module_regs_valid & 16'h0003, 16'h0002);
        wr(4'h5, 16'h0000);
        rd(4'h5, 16'h0001);
        chk(module_run & 16'h0002, 16'h0000);
        chk(module_regs_valid & 16'h0002, 16'h0002);
        wr(4'h5, 16'hFFFF);
        wr(4'h6, 16'h0004);
        go(1'b0, 1'b1);
        chk({15'h0, idle_active}, 16'h0001);
        chk(module_run & 16'h000C, 16'h0008);
        rst_pulse();
        $display("module test done");
    endtask : t_modules
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        true_por <= 1'b0;
        t_flags();
        t_deep();
        t_doze();
        t_modules();
        end_of_test();
    end
    initial begin
        #200000;
        failures++;
        end_of_test();
    end
endmodule : tb_top
bind deep_sleep_doze_power_control power_ctl_monitor #(
    .NUM_MODULES(NUM_MODULES), .NUM_PINS(NUM_PINS),
    .POR_SEQ_CYCLES(POR_SEQ_CYCLES)) u_power_ctl_monitor (.core_clk,
    .reset, .true_por, .wake_ext_irq, .wake_fault, .wake_watchdog,
    .wake_alarm, .wake_master_reset, .por_event, .brownout_event,
    .output_latch, .direction_register, .pin_out, .pin_oe, .io_hold,
    .deep_sleep_active, .sleep_active, .idle_active, .wake_reset,
    .irq_flush, .cpu_clk_en, .periph_clk_en, .module_clk_en, .module_run);
